// [verilog/mux_defines.svh]
// default settings and constants for the pipelined bus multiplexer
`ifndef MUX_DEFINES_SVH
`define MUX_DEFINES_SVH

// ============================================================
// default build settings
`define MUX_N_INPUTS_DEF 4
`define MUX_STAGES_DEF 1
`define MUX_ONE_HOT_DEF 1'b0
`define MUX_USE_ENA_DEF 1'b1
`define MUX_USE_ACLR_DEF 1'b1

// ============================================================
// default per-input formats, integer and fraction bits
`define MUX_IN_INT_W_DEF '{8, 6, 4, 2}
`define MUX_IN_FRAC_W_DEF '{0, 2, 3, 1}

// ============================================================
// constants
`define MUX_MIN_INPUTS 2
`define MUX_CLEAR_BIT 1'b0
`define MUX_ENA_ON 1'b1
`define MUX_ACLR_OFF 1'b0

`endif

// [verilog/mux_pkg.sv]
// types shared by the pipelined bus multiplexer modules
package mux_pkg;

  // ============================================================
  // control pair handed to each pipeline stage
  typedef struct packed {
    logic ena;
    logic aclr;
  } stage_ctl_t;

endpackage

// [verilog/mux_pipe_stage.sv]
// one register stage of the multiplexer pipeline
`include "mux_defines.svh"

module mux_pipe_stage #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // stage control
  input wire mux_pkg::stage_ctl_t ctl,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // ============================================================
  // next value: hold while enable is low
  always_comb
  begin
    q_next = q_reg;
    if (ctl.ena == `MUX_ENA_ON)
    begin
      q_next = d;
    end
  end

  // ============================================================
  // register, cleared at once by the asynchronous clear
  always_ff @(posedge clk or posedge ctl.aclr)
  begin
    if (ctl.aclr)
    begin
      q_reg <= {W{`MUX_CLEAR_BIT}};
    end
    else if (reset)
    begin
      q_reg <= {W{`MUX_CLEAR_BIT}};
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// [verilog/pipelined_bus_multiplexer.sv]
// n-to-1 bus multiplexer with sign extension and optional pipeline
`include "mux_defines.svh"

module pipelined_bus_multiplexer #(
  parameter int N_INPUTS = `MUX_N_INPUTS_DEF,
  parameter int STAGES = `MUX_STAGES_DEF,
  parameter bit ONE_HOT = `MUX_ONE_HOT_DEF,
  parameter bit USE_ENA = `MUX_USE_ENA_DEF,
  parameter bit USE_ACLR = `MUX_USE_ACLR_DEF,
  parameter int IN_INT_W [N_INPUTS] = `MUX_IN_INT_W_DEF,
  parameter int IN_FRAC_W [N_INPUTS] = `MUX_IN_FRAC_W_DEF,
  // derived widths
  parameter int INT_MAX = max_of(IN_INT_W),
  parameter int FRAC_MAX = max_of(IN_FRAC_W),
  parameter int OUT_W = INT_MAX + FRAC_MAX,
  parameter int SEL_W = ONE_HOT ? N_INPUTS : $clog2(N_INPUTS)
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // select and data, input i in slot DIN[i*OUT_W +: OUT_W], low bits used
  input wire logic [SEL_W-1:0] SEL,
  input wire logic [N_INPUTS*OUT_W-1:0] DIN,
  // optional pipeline controls
  input wire logic ENA,
  input wire logic ACLR,
  // result
  output logic [OUT_W-1:0] DOUT
);

  function automatic int max_of(input int v [N_INPUTS]);
    int m;
    m = v[0];
    for (int k = 1; k < N_INPUTS; k++)
    begin
      if (v[k] > m)
      begin
        m = v[k];
      end
    end
    return m;
  endfunction

  // ============================================================
  // build checks, reported while the design is elaborated
  if (N_INPUTS < `MUX_MIN_INPUTS)
  begin : g_few_inputs
    $error("multiplexer needs at least two data inputs");
  end

  if (STAGES < 0)
  begin : g_bad_depth
    $error("pipeline depth cannot be negative");
  end

  // every input needs a format with at least one bit
  for (genvar gc = 0; gc < N_INPUTS; gc++)
  begin : g_fmt_check
    if (IN_INT_W[gc] < 0 || IN_FRAC_W[gc] < 0)
    begin : g_negative
      $error("data input width cannot be negative");
    end
    if (IN_INT_W[gc] + IN_FRAC_W[gc] < 1)
    begin : g_empty
      $error("data input has no bits");
    end
  end

  // ============================================================
  // align binary points and sign extend each input
  logic [OUT_W-1:0] aligned [N_INPUTS];

  for (genvar gi = 0; gi < N_INPUTS; gi++)
  begin : g_align
    localparam int W = IN_INT_W[gi] + IN_FRAC_W[gi];
    localparam int SH = FRAC_MAX - IN_FRAC_W[gi];
    logic signed [W-1:0] raw;
    assign raw = DIN[gi*OUT_W +: W];
    // msb is the sign, copied upward; fraction padded with zeros
    assign aligned[gi] = OUT_W'(raw) << SH;
  end

  // ============================================================
  // selection
  logic [OUT_W-1:0] hot_pick;
  logic [OUT_W-1:0] bin_pick;
  logic [OUT_W-1:0] chosen;

  // one-hot reading: zero unless exactly one bit is set
  always_comb
  begin
    hot_pick = {OUT_W{`MUX_CLEAR_BIT}};
    if ($onehot(SEL))
    begin
      for (int k = 0; k < N_INPUTS && k < SEL_W; k++)
      begin
        if (SEL[k])
        begin
          hot_pick = aligned[k];
        end
      end
    end
  end

  // binary reading: zero for an index past the last input
  always_comb
  begin
    bin_pick = {OUT_W{`MUX_CLEAR_BIT}};
    if (int'(SEL) < N_INPUTS)
    begin
      bin_pick = aligned[int'(SEL)];
    end
  end

  // build option decides which reading reaches the pipeline
  always_comb
  begin
    chosen = bin_pick;
    if (ONE_HOT)
    begin
      chosen = hot_pick;
    end
  end

  // ============================================================
  // pipeline
  mux_pkg::stage_ctl_t ctl;

  // unused controls fall back to always enabled, never cleared
  always_comb
  begin
    ctl.ena = `MUX_ENA_ON;
    ctl.aclr = `MUX_ACLR_OFF;
    if (USE_ENA)
    begin
      ctl.ena = ENA;
    end
    if (USE_ACLR)
    begin
      ctl.aclr = ACLR;
    end
  end

  if (STAGES == 0)
  begin : g_comb
    assign DOUT = chosen;
  end
  else
  begin : g_pipe
    logic [OUT_W-1:0] tap [STAGES+1];
    assign tap[0] = chosen;
    for (genvar gs = 0; gs < STAGES; gs++)
    begin : g_stage
      mux_pipe_stage #(
        .W(OUT_W)
      ) u_stage (
        .clk(CLK),
        .reset(RESET),
        .ctl(ctl),
        .d(tap[gs]),
        .q(tap[gs+1])
      );
    end
    assign DOUT = tap[STAGES];
  end

endmodule

// [bench/mux_chk.sv]
// port assertions for the multiplexer
module mux_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // inputs and result
  input wire logic [1:0] SEL,
  input wire logic [43:0] DIN,
  input wire logic ENA,
  input wire logic ACLR,
  input wire logic [10:0] DOUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_hold_ena: assert property (!ENA && !ACLR |=> ACLR || $stable(DOUT))
    else $error("output moved with enable low");
  chk_aclr_zero: assert property (ACLR |-> DOUT == 11'h000)
    else $error("output not cleared");
  chk_frac_fill: assert property (ENA && !ACLR && SEL == 2'h0 |=> ACLR || DOUT[2:0] == 3'h0)
    else $error("fraction fill wrong");
  chk_pick_two: assert property (ENA && !ACLR && SEL == 2'h2 |=> ACLR ||
    DOUT == {{4{$past(DIN[28])}}, $past(DIN[28:22])}) else $error("input two wrong");
  chk_sign_three: assert property (ENA && !ACLR && SEL == 2'h3 |=> ACLR ||
    DOUT == {{6{$past(DIN[35])}}, $past(DIN[35:33]), 2'h0}) else $error("input three wrong");
  chk_pick_one: assert property (ENA && !ACLR && SEL == 2'h1 |=> ACLR ||
    DOUT == {{2{$past(DIN[18])}}, $past(DIN[18:11]), 1'h0}) else $error("input one wrong");
endmodule
bind pipelined_bus_multiplexer mux_chk chk (.CLK(CLK), .RESET(RESET), .SEL(SEL), .DIN(DIN),
  .ENA(ENA), .ACLR(ACLR), .DOUT(DOUT));

// [bench/mux_src.sv]
// data source standing in for the surrounding datapath
module mux_src (
  input wire logic [10:0] pat,
  output logic [43:0] din
);
  // every slot driven, unused high bits too
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      din[i*11 +: 11] = pat ^ 11'(11'h2a5 * i);
    end
  end
endmodule

// [bench/pipelined_bus_multiplexer_tb_top.sv]
// testbench for the pipelined bus multiplexer
module pipelined_bus_multiplexer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RESET = 1, ENA = 1, ACLR = 0;
  logic [1:0] SEL = 0;
  logic [10:0] pat = 0, DOUT, exp_v;
  logic [43:0] DIN;
  int bad_count = 0, total_checks = 0, cyc = 0;
  mux_src src (.pat(pat), .din(DIN));
  pipelined_bus_multiplexer DUT (.CLK(CLK), .RESET(RESET), .SEL(SEL), .DIN(DIN), .ENA(ENA),
    .ACLR(ACLR), .DOUT(DOUT));
  initial forever #25 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc > 500)
    begin
      bad_count++;
      finish_test();
    end
  end
  // aligned, sign extended view of slot s
  function automatic logic [10:0] al(input logic [1:0] s, input logic [10:0] p);
    logic [10:0] v;
    v = p ^ (11'h2a5 * s);
    case (s)
      2'h0: al = {v[7:0], 3'h0};
      2'h1: al = {{2{v[7]}}, v[7:0], 1'h0};
      2'h2: al = {{4{v[6]}}, v[6:0]};
      default: al = {{6{v[2]}}, v[2:0], 2'h0};
    endcase
  endfunction
  task automatic check(input logic [10:0] e);
    total_checks++;
    if (DOUT !== e)
    begin
      bad_count++;
      $display("MISMATCH DOUT expected %h seen %h", e, DOUT);
    end
  endtask
  task automatic drive(input logic [1:0] s, input logic [10:0] p, input logic e, input logic c);
    @(posedge CLK);
    #5;
    SEL = s;
    pat = p;
    ENA = e;
    ACLR = c;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge CLK);
    #5;
    RESET = 0;
    for (int k = 0; k < 8; k++)
    begin
      drive(k[1:0], 11'(k * 467), 1'b1, 1'b0);
      if (k > 0) check(exp_v);
      exp_v = al(k[1:0], 11'(k * 467));
    end
    drive(2'h2, 11'h7ff, 1'b0, 1'b0);
    check(exp_v);
    drive(2'h1, 11'h0f0, 1'b0, 1'b0);
    check(exp_v);
    drive(2'h1, 11'h0f0, 1'b1, 1'b1);
    #1;
    check(11'h000);
    drive(2'h3, 11'h004, 1'b1, 1'b0);
    check(11'h000);
    drive(2'h3, 11'h004, 1'b1, 1'b0);
    check(al(2'h3, 11'h004));
    finish_test();
  end
endmodule
